// *** logic/eprom_port_pkg.sv ***
package eprom_port_pkg;
    // ------------------------------------------------------------
    // mode codes and array geometry
    // ------------------------------------------------------------
    localparam logic [9:0]  CODE_USER        = 10'h296;
    localparam logic [9:0]  CODE_KEY         = 10'h292;
    localparam logic [9:0]  CODE_SEC_PGM_INH = 10'h29A;
    localparam logic [9:0]  CODE_SEC_VFY_INH = 10'h298;
    localparam int          CODE_BITS        = 10;
    localparam int          ADDR_BITS        = 11;
    localparam int          USER_DEPTH       = 2048;
    localparam int          KEY_DEPTH        = 16;
    localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
    localparam logic [3:0]  BIT_CNT_RESET    = 4'h0;

    // ------------------------------------------------------------
    // timing, in oscillator periods (one i_clk per period)
    // ------------------------------------------------------------
    localparam int          VERIFY_DELAY_T   = 14;
    localparam logic [5:0]  VERIFY_DELAY_CYC = 6'(VERIFY_DELAY_T);
    localparam logic [5:0]  DELAY_RESET      = 6'h00;

    // ------------------------------------------------------------
    // modes decoded from the serial code
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_IDLE    = 3'b000,
        MODE_USER    = 3'b001,
        MODE_KEY     = 3'b010,
        MODE_SEC_PI  = 3'b011,
        MODE_SEC_VI  = 3'b100
    } mode_t;
endpackage

// *** logic/mode_shifter.sv ***
// ------------------------------------------------------------
// serial mode-code receiver on the reset pin
// ------------------------------------------------------------
module mode_shifter (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_serial_in,
    input  wire logic                  i_shift_en,
    output eprom_port_pkg::mode_t      o_mode
);
    logic [9:0]                  code_ff;
    logic [3:0]                  cnt_ff;
    eprom_port_pkg::mode_t       mode_ff;
    eprom_port_pkg::mode_t       nxt_mode;
    logic                        last_bit;
    logic [9:0]                  nxt_code;

    // lsb first: new bits enter at the top and walk down
    assign nxt_code = {i_serial_in, code_ff[9:1]};
    assign last_bit = i_shift_en && (cnt_ff == 4'(eprom_port_pkg::CODE_BITS - 1));

    always_comb begin
        nxt_mode = eprom_port_pkg::MODE_IDLE;
        unique case (nxt_code)
            eprom_port_pkg::CODE_USER:        nxt_mode = eprom_port_pkg::MODE_USER;
            eprom_port_pkg::CODE_KEY:         nxt_mode = eprom_port_pkg::MODE_KEY;
            eprom_port_pkg::CODE_SEC_PGM_INH: nxt_mode = eprom_port_pkg::MODE_SEC_PI;
            eprom_port_pkg::CODE_SEC_VFY_INH: nxt_mode = eprom_port_pkg::MODE_SEC_VI;
            default:                          nxt_mode = eprom_port_pkg::MODE_IDLE;
        endcase
    end

    // mode is latched once the tenth bit arrives and held until the next full code or device reset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            code_ff <= 10'h000;
            cnt_ff  <= eprom_port_pkg::BIT_CNT_RESET;
            mode_ff <= eprom_port_pkg::MODE_IDLE;
        end else if (last_bit) begin
            code_ff <= nxt_code;
            cnt_ff  <= eprom_port_pkg::BIT_CNT_RESET;
            mode_ff <= nxt_mode;
        end else if (i_shift_en) begin
            code_ff <= nxt_code;
            cnt_ff  <= cnt_ff + 4'h1;
        end
    end

    assign o_mode = mode_ff;
endmodule

// *** logic/eprom_program_verify_port.sv ***
// Overview of operation
// - security verify ignores address, drives bits 6-7
// - bit 7 shows program-inhibit bit state
// - bit 6 shows verify-inhibit bit state
// - erased cells read back as ones
// - code 296H selects user array
// - code 292H selects key array
// - 29AH with pulses programs program-inhibit
// - 298H with pulses programs verify-inhibit
// - 29AH with strobe high, voltage normal verifies security
// - verify data within 48 periods after voltage
// - pure verify data within 14 periods
// - data valid 48 periods after low address
// - ten-bit code, lsb first, sampled clock high
// - user verify XNORs byte with key byte
// - program-inhibit blocks array programming and key verify
module eprom_program_verify_port (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_serial_code,
    input  wire logic        i_code_shift_en,
    input  wire logic        i_program_strobe_n,
    input  wire logic        i_program_voltage_input,
    input  wire logic        i_address_byte_select,
    input  wire logic [7:0]  i_addr_port,
    input  wire logic [7:0]  i_data_port,
    output logic      [7:0]  o_data_port,
    output logic      [7:0]  o_data_port_oe,
    output logic             o_verify_valid
);
    // ------------------------------------------------------------
    // storage: user array, key array and the two security bits
    // ------------------------------------------------------------
    logic [7:0]                 user_mem [eprom_port_pkg::USER_DEPTH];
    logic [7:0]                 key_mem  [eprom_port_pkg::KEY_DEPTH];
    logic                       sec_pi_ff;
    logic                       sec_vi_ff;
    logic [eprom_port_pkg::USER_DEPTH-1:0] user_written_ff;
    logic [eprom_port_pkg::KEY_DEPTH-1:0]  key_written_ff;
    logic [2:0]                 hi_addr_ff;
    logic [7:0]                 lo_addr_ff;
    logic                       strobe_d_ff;
    logic                       vpp_d_ff;
    logic [5:0]                 delay_ff;
    logic [5:0]                 nxt_delay;
    logic [7:0]                 data_ff;
    logic [7:0]                 nxt_data;
    logic [7:0]                 oe_ff;
    logic [7:0]                 nxt_oe;
    logic                       valid_ff;
    eprom_port_pkg::mode_t      mode;

    // the ten code bits are gathered lsb first by the receiver below
    mode_shifter u_mode (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_serial_in (i_serial_code),
        .i_shift_en  (i_code_shift_en),
        .o_mode      (mode)
    );

    // ------------------------------------------------------------
    // decode of operation from mode and pin levels
    // ------------------------------------------------------------
    wire [10:0] addr       = {hi_addr_ff, lo_addr_ff};
    wire        pulse_rise = i_program_strobe_n && !strobe_d_ff;
    wire        vpp_fall   = vpp_d_ff && !i_program_voltage_input;
    wire        verifying  = i_program_strobe_n && !i_program_voltage_input;
    wire        lo_change  = !i_address_byte_select && (i_addr_port != lo_addr_ff);
    // program-inhibit blocks writes to both arrays
    wire        pgm_user   = pulse_rise && i_program_voltage_input
                             && (mode == eprom_port_pkg::MODE_USER) && !sec_pi_ff;
    wire        pgm_key    = pulse_rise && i_program_voltage_input
                             && (mode == eprom_port_pkg::MODE_KEY) && !sec_pi_ff;
    // security programming ignores address and data ports
    wire        pgm_sec_pi = pulse_rise && i_program_voltage_input
                             && (mode == eprom_port_pkg::MODE_SEC_PI);
    wire        pgm_sec_vi = pulse_rise && i_program_voltage_input
                             && (mode == eprom_port_pkg::MODE_SEC_VI);
    // unwritten cells read as the erased pattern, so the arrays need no reset
    function automatic logic [7:0] cell_value(input logic written, input logic [7:0] stored);
        cell_value = written ? stored : eprom_port_pkg::ERASED_BYTE;
    endfunction

    wire [7:0]  user_raw   = cell_value(user_written_ff[addr], user_mem[addr]);
    wire [7:0]  key_raw    = cell_value(key_written_ff[addr[3:0]], key_mem[addr[3:0]]);
    // verify data is the stored byte xnor the key byte for address mod 16
    wire [7:0]  user_vfy   = ~(user_raw ^ key_raw);

    // ------------------------------------------------------------
    // settle tracking
    // ------------------------------------------------------------
    // anything that changes what is read restarts the delay: the end of a program
    // step, a new code, a high byte under select or a new low byte
    wire        reload     = !verifying || vpp_fall || lo_change
                             || i_code_shift_en || i_address_byte_select;

    // ------------------------------------------------------------
    // pin sampling and address latch
    // ------------------------------------------------------------
    // high bits latch while select is high; low byte follows the port
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hi_addr_ff  <= 3'h0;
            lo_addr_ff  <= 8'h00;
            strobe_d_ff <= 1'b1;
            vpp_d_ff    <= 1'b0;
        end else begin
            if (i_address_byte_select)
                hi_addr_ff <= i_addr_port[2:0];
            else
                lo_addr_ff <= i_addr_port;
            strobe_d_ff <= i_program_strobe_n;
            vpp_d_ff    <= i_program_voltage_input;
        end
    end

    // ------------------------------------------------------------
    // array writes: eprom cells only move from one to zero
    // ------------------------------------------------------------
    // repeated pulses of the same byte are idempotent, so 25 pulses are harmless
    always_ff @(posedge i_clk) begin
        if (pgm_user)
            user_mem[addr] <= user_raw & i_data_port;
        if (pgm_key)
            key_mem[addr[3:0]] <= key_raw & i_data_port;
    end

    // per-cell written bits stand in for an all-ones array after power-up
    // a single shared flag would expose unwritten cells once any cell was burnt
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            user_written_ff <= '0;
            key_written_ff  <= '0;
            sec_pi_ff       <= 1'b0;
            sec_vi_ff       <= 1'b0;
        end else begin
            if (pgm_user)
                user_written_ff[addr] <= 1'b1;
            if (pgm_key)
                key_written_ff[addr[3:0]] <= 1'b1;
            if (pgm_sec_pi)
                sec_pi_ff <= 1'b1;
            if (pgm_sec_vi)
                sec_vi_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // verify delay counter
    // ------------------------------------------------------------
    // a fixed 14-period delay satisfies both the 48 and the 14 limits
    always_comb begin
        nxt_delay = delay_ff;
        if (reload)
            nxt_delay = eprom_port_pkg::VERIFY_DELAY_CYC;
        else if (delay_ff != eprom_port_pkg::DELAY_RESET)
            nxt_delay = delay_ff - 6'h01;
    end

    // ------------------------------------------------------------
    // verify output selection
    // ------------------------------------------------------------
    // the data port is an input whenever high voltage is applied
    always_comb begin
        nxt_data = 8'h00;
        nxt_oe   = 8'h00;
        if (verifying) begin
            unique case (mode)
                eprom_port_pkg::MODE_USER: begin
                    if (!sec_vi_ff) begin
                        nxt_data = user_vfy;
                        nxt_oe   = 8'hFF;
                    end
                end
                eprom_port_pkg::MODE_KEY: begin
                    if (!sec_vi_ff && !sec_pi_ff) begin
                        nxt_data = key_raw;
                        nxt_oe   = 8'hFF;
                    end
                end
                eprom_port_pkg::MODE_SEC_PI: begin
                    // address port is not consulted here
                    nxt_data = {sec_pi_ff, sec_vi_ff, 6'h00};
                    nxt_oe   = 8'hC0;
                end
                default: begin
                    nxt_data = 8'h00;
                    nxt_oe   = 8'h00;
                end
            endcase
        end
    end

    // valid needs a driven read that has sat undisturbed for the whole delay
    wire        settled    = verifying && (nxt_oe != 8'h00) && (nxt_delay == eprom_port_pkg::DELAY_RESET);

    // outputs are registered; valid rises when the delay expires
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            delay_ff <= eprom_port_pkg::VERIFY_DELAY_CYC;
            data_ff  <= 8'h00;
            oe_ff    <= 8'h00;
            valid_ff <= 1'b0;
        end else begin
            delay_ff <= nxt_delay;
            data_ff  <= nxt_data;
            oe_ff    <= nxt_oe;
            valid_ff <= settled;
        end
    end

    // pins come straight from their flip-flops
    assign o_data_port    = data_ff;
    assign o_data_port_oe = oe_ff;
    assign o_verify_valid = valid_ff;
endmodule

// *** tb/eprom_port_asserts.sv ***
module eprom_port_asserts (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_code_shift_en,
    input wire logic       i_program_strobe_n,
    input wire logic       i_program_voltage_input,
    input wire logic       i_address_byte_select,
    input wire logic [7:0] i_addr_port,
    input wire logic [7:0] o_data_port,
    input wire logic [7:0] o_data_port_oe,
    input wire logic       o_verify_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [4:0] calm_ff;
    // cycles of undisturbed verify; any reload cause restarts the count
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            calm_ff <= 5'h00;
        else if (o_data_port_oe == 8'h00 || i_program_voltage_input || !i_program_strobe_n
                 || i_code_shift_en || i_address_byte_select || $changed(i_addr_port))
            calm_ff <= 5'h00;
        else if (calm_ff != 5'h1F)
            calm_ff <= calm_ff + 5'h01;
    end
    a_sec_upper_only: assert property (
        o_data_port_oe == 8'hC0 |-> o_data_port[5:0] == 6'h00) else $error("low bits set");
    a_oe_two_masks: assert property (
        o_verify_valid |-> o_data_port_oe inside {8'hFF, 8'hC0}) else $error("bad drive mask");
    a_pgm_releases: assert property (
        i_program_voltage_input |=> o_data_port_oe == 8'h00) else $error("drove during program");
    a_verify_in_time: assert property (
        calm_ff >= 5'h10 |-> o_verify_valid) else $error("verify data late");
    a_valid_needs_oe: assert property (
        o_verify_valid |-> o_data_port_oe != 8'h00) else $error("valid without drive");
    a_vpp_drops_valid: assert property (
        i_program_voltage_input |=> !o_verify_valid) else $error("valid under voltage");
    a_low_byte_reload: assert property (
        $changed(i_addr_port) && !i_address_byte_select && o_data_port_oe == 8'hFF
        |=> !o_verify_valid) else $error("stale data kept valid");
    a_data_holds: assert property (
        o_verify_valid && $past(o_verify_valid) |-> $stable(o_data_port)) else $error("data moved");
endmodule

bind eprom_program_verify_port eprom_port_asserts u_eprom_port_asserts (.i_clk, .i_reset,
    .i_code_shift_en, .i_program_strobe_n, .i_program_voltage_input, .i_address_byte_select,
    .i_addr_port, .o_data_port, .o_data_port_oe, .o_verify_valid);

// *** tb/eprom_programmer.sv ***
module eprom_programmer #(
    parameter int PULSE_T = 8
) (
    input  wire logic       i_clk,
    output logic            o_serial_code,
    output logic            o_code_shift_en,
    output logic            o_program_strobe_n,
    output logic            o_program_voltage_input,
    output logic            o_address_byte_select,
    output logic      [7:0] o_addr_port,
    output logic      [7:0] o_data_port
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: strobe high, normal voltage
    initial begin
        o_serial_code = 1'b0;
        o_code_shift_en = 1'b0;
        o_program_strobe_n = 1'b1;
        o_program_voltage_input = 1'b0;
        o_address_byte_select = 1'b0;
        o_addr_port = 8'h00;
        o_data_port = 8'hA5;
    end
    // ten code bits, lsb first
    task automatic send_code(input logic [9:0] c);
        // the sync pin is not wired to this block; its 4 low and 8 high periods still pace the code
        repeat (12) @(negedge i_clk);
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk);
            o_serial_code = c[i];
            o_code_shift_en = 1'b1;
        end
        @(negedge i_clk);
        o_code_shift_en = 1'b0;
        o_serial_code = 1'b0;
    endtask
    // high bits under select, then the low byte
    task automatic set_addr(input logic [10:0] a);
        @(negedge i_clk);
        o_address_byte_select = 1'b1;
        o_addr_port = {5'h00, a[10:8]};
        repeat (13) @(negedge i_clk);
        o_address_byte_select = 1'b0;
        repeat (2) @(negedge i_clk);
        o_addr_port = a[7:0];
        repeat (24) @(negedge i_clk);
    endtask
    // widths scaled down: the block does not time pulses, real ones cost 90k cycles
    task automatic burn(input logic [7:0] d);
        o_data_port = d;
        o_program_voltage_input = 1'b1;
        repeat (38) @(negedge i_clk);
        repeat (25) begin
            o_program_strobe_n = 1'b0;
            repeat (PULSE_T) @(negedge i_clk);
            o_program_strobe_n = 1'b1;
            repeat (PULSE_T) @(negedge i_clk);
        end
        repeat (48) @(negedge i_clk);
        o_program_voltage_input = 1'b0;
        o_data_port = ~d; // released port stops showing the byte
    endtask
endmodule

// *** tb/eprom_program_verify_port_bench.sv ***
module eprom_program_verify_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_serial_code, i_code_shift_en, i_program_strobe_n;
    logic        i_program_voltage_input, i_address_byte_select, o_verify_valid;
    logic  [7:0] i_addr_port, i_data_port, o_data_port, o_data_port_oe;
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed = 32'hB2197A28;
    logic  [7:0] user_m [2048];
    logic  [7:0] key_m [16];
    logic        pi_m = 1'b0;
    logic        vi_m = 1'b0;
    logic [10:0] a;
    eprom_program_verify_port u_eprom_program_verify_port (.i_clk, .i_reset, .i_serial_code,
        .i_code_shift_en, .i_program_strobe_n, .i_program_voltage_input, .i_address_byte_select,
        .i_addr_port, .i_data_port, .o_data_port, .o_data_port_oe, .o_verify_valid);
    eprom_programmer u_write_pulse_n (.i_clk, .o_serial_code(i_serial_code), .o_code_shift_en(i_code_shift_en),
        .o_program_strobe_n(i_program_strobe_n), .o_program_voltage_input(i_program_voltage_input),
        .o_address_byte_select(i_address_byte_select), .o_addr_port(i_addr_port),
        .o_data_port(i_data_port));
    always #12.5 i_clk = ~i_clk;
    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // pick a mode, then burn d or wait for the readback and compare it
    task automatic op(input logic [9:0] c, input bit pgm, input bit adr, input logic [7:0] d,
                      input logic [7:0] eoe);
        u_write_pulse_n.send_code(c);
        if (adr)
            u_write_pulse_n.set_addr(a);
        if (pgm)
            u_write_pulse_n.burn(d);
        else begin
            for (int k = 0; k < 60 && o_verify_valid !== 1'b1; k++)
                @(negedge i_clk);
            check(o_data_port_oe, eoe);
            check(o_data_port & eoe, d);
            check({7'h00, o_verify_valid}, {7'h00, eoe != 8'h00});
        end
    endtask
    initial begin
        foreach (user_m[i])
            user_m[i] = 8'hFF;
        foreach (key_m[i])
            key_m[i] = 8'hFF;
        repeat (6) @(negedge i_clk);
        i_reset = 1'b0;
        a = 11'($random(seed));
        op(eprom_port_pkg::CODE_USER, 0, 1, 8'hFF, 8'hFF);
        op(eprom_port_pkg::CODE_KEY, 0, 1, 8'hFF, 8'hFF);
        op(eprom_port_pkg::CODE_SEC_PGM_INH, 0, 0, 8'h00, 8'hC0);
        key_m[a[3:0]] = 8'($random(seed));
        op(eprom_port_pkg::CODE_KEY, 1, 1, key_m[a[3:0]], 8'h00);
        user_m[a] = 8'($random(seed));
        op(eprom_port_pkg::CODE_USER, 1, 1, user_m[a], 8'h00);
        op(eprom_port_pkg::CODE_USER, 0, 1, ~(user_m[a] ^ key_m[a[3:0]]), 8'hFF);
        op(eprom_port_pkg::CODE_KEY, 0, 1, key_m[a[3:0]], 8'hFF);
        op(eprom_port_pkg::CODE_SEC_PGM_INH, 1, 0, 8'h00, 8'h00);
        pi_m = 1'b1;
        op(eprom_port_pkg::CODE_USER, 1, 1, 8'h00, 8'h00);
        if (!pi_m)
            user_m[a] = 8'h00;
        op(eprom_port_pkg::CODE_USER, 0, 1, ~(user_m[a] ^ key_m[a[3:0]]), 8'hFF);
        op(eprom_port_pkg::CODE_KEY, 0, 1, 8'h00, 8'h00);
        op(eprom_port_pkg::CODE_SEC_PGM_INH, 0, 0, {pi_m, vi_m, 6'h00}, 8'hC0);
        op(eprom_port_pkg::CODE_SEC_VFY_INH, 1, 0, 8'h00, 8'h00);
        vi_m = 1'b1;
        op(eprom_port_pkg::CODE_SEC_PGM_INH, 0, 0, {pi_m, vi_m, 6'h00}, 8'hC0);
        op(eprom_port_pkg::CODE_SEC_VFY_INH, 0, 0, 8'h00, 8'h00);
        op(eprom_port_pkg::CODE_USER, 0, 1, 8'h00, 8'h00);
        give_verdict();
    end
endmodule
